// ===== hw/range_result_output_framer.sv
// Range result framer: binary or text frames to a byte stream, an I2C slave
// that serves the latest binary frame, and a near/far switch level.
// Assumes a byte transmitter downstream and I2C pins from outside the clock.
`timescale 1ns/1ps

module byte_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [PW-1:0]    wr_ptr_ff;
   logic [PW-1:0]    rd_ptr_ff;
   logic [PW:0]      count_ff;
   logic             push;
   logic             pop;

   assign in_ready_o  = (count_ff != (PW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign out_data_o  = mem_ff[rd_ptr_ff];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff  <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
         end
         if (push && !pop) begin
            count_ff <= count_ff + (PW+1)'(1);
         end else if (pop && !push) begin
            count_ff <= count_ff - (PW+1)'(1);
         end
      end
   end
endmodule

module range_result_output_framer (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        meas_valid_i,
   input  wire logic [15:0] meas_dist_i,
   input  wire logic [15:0] meas_strength_i,
   input  wire logic [15:0] meas_temp_i,
   input  wire logic        fmt_wr_i,
   input  wire logic        fmt_text_i,
   input  wire logic        io_wr_i,
   input  wire logic        io_mode_i,
   input  wire logic [15:0] crit_dist_i,
   input  wire logic [15:0] hyst_i,
   input  wire logic        addr_wr_i,
   input  wire logic [6:0]  i2c_addr_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic      [7:0]  tx_data_o,
   output logic             busy_o,
   output logic             switch_o,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   output logic             cmd_valid_o,
   output logic      [7:0]  cmd_data_o
);
   import framer_pkg::*;

   framer_pkg::fmt_type       fmt_ff;
   framer_pkg::i2c_state_type i2c_st_ff;
   logic        mode_ff;
   logic [15:0] crit_ff;
   logic [15:0] hyst_ff;
   logic [6:0]  addr_ff;
   logic [7:0]  tx_buf_ff [FRAME_LEN];
   logic [7:0]  last_ff [FRAME_LEN];
   logic [7:0]  rd_buf_ff [FRAME_LEN];
   logic [3:0]  tx_len_ff;
   logic [3:0]  tx_idx_ff;
   logic        busy_ff;
   logic        sw_ff;
   logic        out_valid_ff;
   logic [7:0]  out_data_ff;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [7:0]  fifo_out_data;
   logic [15:0] dist_eff;
   logic        scl_s1_ff, scl_s2_ff, scl_d_ff;
   logic        sda_s1_ff, sda_s2_ff, sda_d_ff;
   logic        scl_rise, scl_fall, i2c_start, i2c_stop;
   logic [3:0]  bit_cnt_ff;
   logic [7:0]  rx_sh_ff;
   logic [7:0]  tx_sh_ff;
   logic        rw_ff;
   logic        nack_ff;
   logic [3:0]  rd_idx_ff;
   logic        sda_oe_ff;
   logic        cmd_valid_ff;
   logic [7:0]  cmd_data_ff;

   // Binary frame byte at position i, fields least significant byte first.
   function automatic logic [7:0] bin_byte(input logic [3:0] i, input logic [15:0] d,
                                           input logic [15:0] s, input logic [15:0] t);
      logic [7:0] sum;
      sum = HDR_BYTE + HDR_BYTE + d[7:0] + d[15:8] + s[7:0] + s[15:8] + t[7:0] + t[15:8];
      unique case (i)
         IDX_HDR0, IDX_HDR1: bin_byte = HDR_BYTE;
         IDX_DIST_L: bin_byte = d[7:0];
         IDX_DIST_H: bin_byte = d[15:8];
         IDX_STR_L:  bin_byte = s[7:0];
         IDX_STR_H:  bin_byte = s[15:8];
         IDX_TMP_L:  bin_byte = t[7:0];
         IDX_TMP_H:  bin_byte = t[15:8];
         default:    bin_byte = sum;
      endcase
   endfunction

   function automatic logic [7:0] digit(input logic [15:0] v);
      digit = CHR_ZERO + v[7:0];
   endfunction

   function automatic logic metres_wide(input logic [15:0] d);
      metres_wide = (d / CM_PER_M) >= DEC_TEN;
   endfunction

   // Text character at position i: metres, dot, two centimetre digits, CR, LF.
   function automatic logic [7:0] text_byte(input logic [3:0] i, input logic [15:0] d);
      logic [15:0] m;
      logic [15:0] c;
      logic [3:0]  p;
      m = d / CM_PER_M;
      c = d % CM_PER_M;
      p = metres_wide(d) ? i : i + IDX_STEP;
      unique case (p)
         IDX_HDR0:   text_byte = digit(m / DEC_TEN);
         IDX_HDR1:   text_byte = digit(m % DEC_TEN);
         IDX_DIST_L: text_byte = CHR_DOT;
         IDX_DIST_H: text_byte = digit(c / DEC_TEN);
         IDX_STR_L:  text_byte = digit(c % DEC_TEN);
         IDX_STR_H:  text_byte = CHR_CR;
         default:    text_byte = CHR_LF;
      endcase
   endfunction

   always_comb begin
      if (meas_strength_i < STR_MIN) begin
         dist_eff = DIST_MAX;
      end else if (meas_dist_i > DIST_MAX) begin
         dist_eff = DIST_MAX;
      end else begin
         dist_eff = meas_dist_i;
      end
   end

   // Configuration written by the command decoder outside this block.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fmt_ff  <= FMT_BIN;
         mode_ff <= MODE_DATA;
         crit_ff <= CRIT_RST;
         hyst_ff <= HYST_RST;
         addr_ff <= I2C_ADDR_RST;
      end else begin
         if (fmt_wr_i) begin
            fmt_ff <= fmt_text_i ? FMT_TEXT : FMT_BIN;
         end
         if (io_wr_i) begin
            mode_ff <= io_mode_i;
            crit_ff <= crit_dist_i;
            hyst_ff <= hyst_i;
         end
         if (addr_wr_i && i2c_addr_i != I2C_ADDR_NONE) begin
            addr_ff <= i2c_addr_i;
         end
      end
   end

   // Frame assembly; a measurement arriving while busy is dropped.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         busy_ff   <= 1'b0;
         tx_idx_ff <= '0;
         tx_len_ff <= BIN_LEN;
      end else if (meas_valid_i && !busy_ff && mode_ff == MODE_DATA) begin
         busy_ff   <= 1'b1;
         tx_idx_ff <= '0;
         if (fmt_ff == FMT_TEXT) begin
            tx_len_ff <= metres_wide(dist_eff) ? TXT_LONG : TXT_SHORT;
         end else begin
            tx_len_ff <= BIN_LEN;
         end
      end else if (busy_ff && fifo_in_ready) begin
         tx_idx_ff <= tx_idx_ff + IDX_STEP;
         if (tx_idx_ff == tx_len_ff - IDX_STEP) begin
            busy_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < FRAME_LEN; i++) begin
         if (meas_valid_i && !busy_ff) begin
            tx_buf_ff[i] <= (fmt_ff == FMT_TEXT) ? text_byte(4'(i), dist_eff) :
                            bin_byte(4'(i), dist_eff, meas_strength_i, meas_temp_i);
         end
         if (meas_valid_i) begin
            last_ff[i] <= bin_byte(4'(i), dist_eff, meas_strength_i, meas_temp_i);
         end
      end
   end

   // Near/far switch level with hysteresis band.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sw_ff <= SW_FAR;
      end else if (meas_valid_i) begin
         if (sw_ff == SW_NEAR && {1'b0, dist_eff} > {1'b0, crit_ff} + {1'b0, hyst_ff}) begin
            sw_ff <= SW_FAR;
         end else if (sw_ff == SW_FAR && dist_eff < crit_ff) begin
            sw_ff <= SW_NEAR;
         end
      end
   end

   byte_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (busy_ff),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (tx_buf_ff[tx_idx_ff]),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   assign fifo_out_ready = !out_valid_ff || tx_ready_i;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         out_valid_ff <= 1'b0;
         out_data_ff  <= '0;
      end else if (fifo_out_ready) begin
         out_valid_ff <= fifo_out_valid;
         if (fifo_out_valid) begin
            out_data_ff <= fifo_out_data;
         end
      end
   end

   // I2C pin synchronisers and bus condition detection.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         {scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
         {sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
      end else begin
         {scl_s1_ff, scl_s2_ff, scl_d_ff} <= {scl_i, scl_s1_ff, scl_s2_ff};
         {sda_s1_ff, sda_s2_ff, sda_d_ff} <= {sda_i, sda_s1_ff, sda_s2_ff};
      end
   end

   assign scl_rise  = scl_s2_ff && !scl_d_ff;
   assign scl_fall  = !scl_s2_ff && scl_d_ff;
   assign i2c_start = scl_s2_ff && scl_d_ff && !sda_s2_ff && sda_d_ff;
   assign i2c_stop  = scl_s2_ff && scl_d_ff && sda_s2_ff && !sda_d_ff;

   // Slave only: the block never drives SCL and answers only when addressed.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         i2c_st_ff    <= I2C_IDLE;
         bit_cnt_ff   <= '0;
         rx_sh_ff     <= '0;
         tx_sh_ff     <= '0;
         rw_ff        <= 1'b0;
         nack_ff      <= 1'b0;
         rd_idx_ff    <= '0;
         sda_oe_ff    <= 1'b0;
         cmd_valid_ff <= 1'b0;
         cmd_data_ff  <= '0;
      end else begin
         cmd_valid_ff <= 1'b0;
         if (i2c_stop) begin
            i2c_st_ff <= I2C_IDLE;
            sda_oe_ff <= 1'b0;
         end else if (i2c_start) begin
            i2c_st_ff  <= I2C_ADDR;
            bit_cnt_ff <= '0;
            sda_oe_ff  <= 1'b0;
         end else if (scl_rise) begin
            if (i2c_st_ff == I2C_ADDR || i2c_st_ff == I2C_WRITE) begin
               rx_sh_ff   <= {rx_sh_ff[6:0], sda_s2_ff};
               bit_cnt_ff <= bit_cnt_ff + IDX_STEP;
            end else if (i2c_st_ff == I2C_READ) begin
               bit_cnt_ff <= bit_cnt_ff + IDX_STEP;
            end else if (i2c_st_ff == I2C_ACK_RD) begin
               nack_ff <= sda_s2_ff;
            end
         end else if (scl_fall) begin
            unique case (i2c_st_ff)
               I2C_ADDR: begin
                  if (bit_cnt_ff == BITS_BYTE) begin
                     if (rx_sh_ff[7:1] == addr_ff) begin
                        i2c_st_ff <= I2C_ACK_ADDR;
                        rw_ff     <= rx_sh_ff[0];
                        sda_oe_ff <= 1'b1;
                     end else begin
                        i2c_st_ff <= I2C_IDLE;
                     end
                  end
               end
               I2C_ACK_ADDR: begin
                  bit_cnt_ff <= '0;
                  if (rw_ff) begin
                     i2c_st_ff <= I2C_READ;
                     rd_buf_ff <= last_ff;
                     rd_idx_ff <= IDX_STEP;
                     sda_oe_ff <= !last_ff[0][7];
                     tx_sh_ff  <= {last_ff[0][6:0], 1'b1};
                  end else begin
                     i2c_st_ff <= I2C_WRITE;
                     sda_oe_ff <= 1'b0;
                  end
               end
               I2C_WRITE: begin
                  if (bit_cnt_ff == BITS_BYTE) begin
                     i2c_st_ff    <= I2C_ACK_WR;
                     sda_oe_ff    <= 1'b1;
                     cmd_valid_ff <= 1'b1;
                     cmd_data_ff  <= rx_sh_ff;
                  end
               end
               I2C_ACK_WR: begin
                  i2c_st_ff  <= I2C_WRITE;
                  bit_cnt_ff <= '0;
                  sda_oe_ff  <= 1'b0;
               end
               I2C_READ: begin
                  if (bit_cnt_ff == BITS_BYTE) begin
                     i2c_st_ff <= I2C_ACK_RD;
                     sda_oe_ff <= 1'b0;
                  end else begin
                     sda_oe_ff <= !tx_sh_ff[7];
                     tx_sh_ff  <= {tx_sh_ff[6:0], 1'b1};
                  end
               end
               I2C_ACK_RD: begin
                  if (nack_ff) begin
                     i2c_st_ff <= I2C_IDLE;
                  end else begin
                     i2c_st_ff  <= I2C_READ;
                     bit_cnt_ff <= '0;
                     sda_oe_ff  <= !rd_buf_ff[rd_idx_ff][7];
                     tx_sh_ff   <= {rd_buf_ff[rd_idx_ff][6:0], 1'b1};
                     rd_idx_ff  <= (rd_idx_ff == IDX_SUM) ? '0 : rd_idx_ff + IDX_STEP;
                  end
               end
               default: begin
                  sda_oe_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   assign tx_valid_o  = out_valid_ff;
   assign tx_data_o   = out_data_ff;
   assign busy_o      = busy_ff;
   assign switch_o    = sw_ff;
   assign sda_o       = 1'b0;
   assign sda_oe_o    = sda_oe_ff;
   assign cmd_valid_o = cmd_valid_ff;
   assign cmd_data_o  = cmd_data_ff;
endmodule

// ===== hw/framer_pkg.sv
// Constants and types shared by the range result framer.
// Assumes one 200 MHz clock and a synchronous, active-high reset.
package framer_pkg;
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FRAME_LEN  = 9;
   localparam logic [3:0]  IDX_HDR0   = 4'h0;
   localparam logic [3:0]  IDX_HDR1   = 4'h1;
   localparam logic [3:0]  IDX_DIST_L = 4'h2;
   localparam logic [3:0]  IDX_DIST_H = 4'h3;
   localparam logic [3:0]  IDX_STR_L  = 4'h4;
   localparam logic [3:0]  IDX_STR_H  = 4'h5;
   localparam logic [3:0]  IDX_TMP_L  = 4'h6;
   localparam logic [3:0]  IDX_TMP_H  = 4'h7;
   localparam logic [3:0]  IDX_SUM    = 4'h8;
   localparam logic [3:0]  BIN_LEN    = 4'h9;
   localparam logic [3:0]  TXT_LONG   = 4'h7;
   localparam logic [3:0]  TXT_SHORT  = 4'h6;
   localparam logic [3:0]  IDX_STEP   = 4'h1;
   localparam logic [3:0]  BITS_BYTE  = 4'h8;
   localparam logic [7:0]  HDR_BYTE   = 8'h59;
   localparam logic [15:0] DIST_MAX   = 16'h1194;
   localparam logic [15:0] STR_MIN    = 16'h003c;
   localparam logic [15:0] CM_PER_M   = 16'h0064;
   localparam logic [15:0] DEC_TEN    = 16'h000a;
   localparam logic [7:0]  CHR_ZERO   = 8'h30;
   localparam logic [7:0]  CHR_DOT    = 8'h2e;
   localparam logic [7:0]  CHR_CR     = 8'h0d;
   localparam logic [7:0]  CHR_LF     = 8'h0a;
   localparam logic [6:0]  I2C_ADDR_RST = 7'h10;
   localparam logic [6:0]  I2C_ADDR_NONE = 7'h00;
   localparam logic [15:0] CRIT_RST   = 16'h0000;
   localparam logic [15:0] HYST_RST   = 16'h0000;
   localparam logic        MODE_DATA  = 1'b0;
   localparam logic        SW_NEAR    = 1'b0;
   localparam logic        SW_FAR     = 1'b1;
   typedef enum logic {FMT_BIN, FMT_TEXT} fmt_type;
   typedef enum logic [2:0] {I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_WRITE,
                             I2C_ACK_WR, I2C_READ, I2C_ACK_RD} i2c_state_type;
endpackage

// ===== bench/framer_sva.sv
// Checker of the framer's stream, switch, pin and reset relations.
// Bound from the bench to the framer top; it sees only that module's ports.
`timescale 1ns/1ps
module framer_sva
   import framer_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        meas_valid_i,
   input wire logic [15:0] meas_dist_i,
   input wire logic [15:0] meas_strength_i,
   input wire logic        fmt_wr_i,
   input wire logic        fmt_text_i,
   input wire logic        io_wr_i,
   input wire logic        io_mode_i,
   input wire logic [15:0] crit_dist_i,
   input wire logic [15:0] hyst_i,
   input wire logic        tx_ready_i,
   input wire logic        tx_valid_o,
   input wire logic [7:0]  tx_data_o,
   input wire logic        busy_o,
   input wire logic        switch_o,
   input wire logic        sda_o,
   input wire logic        sda_oe_o,
   input wire logic        cmd_valid_o
);
   logic        txt_ff;
   logic        mode_ff;
   logic [15:0] crit_ff;
   logic [16:0] far_ff;
   logic [15:0] eff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Distance as the switch sees it: weak returns and overrange both read 4500.
   assign eff = (meas_strength_i < STR_MIN || meas_dist_i > DIST_MAX) ? DIST_MAX : meas_dist_i;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         txt_ff <= 1'b0;
      end else if (fmt_wr_i) begin
         txt_ff <= fmt_text_i;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mode_ff <= MODE_DATA;
         crit_ff <= CRIT_RST;
         far_ff  <= {1'b0, CRIT_RST} + {1'b0, HYST_RST};
      end else if (io_wr_i) begin
         mode_ff <= io_mode_i;
         crit_ff <= crit_dist_i;
         far_ff  <= {1'b0, crit_dist_i} + {1'b0, hyst_i};
      end
   end
   property p_hdr;
      $rose(busy_o) && !tx_valid_o && !txt_ff |-> ##[1:3] tx_valid_o && tx_data_o == HDR_BYTE;
   endproperty
   a_hdr: assert property (p_hdr) else $error("frame does not open with header");
   property p_hold;
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while stalled");
   property p_near_far;
      meas_valid_i && !switch_o && {1'b0, eff} > far_ff |=> switch_o;
   endproperty
   a_near_far: assert property (p_near_far) else $error("switch stayed near");
   property p_far_near;
      meas_valid_i && switch_o && eff < crit_ff |=> !switch_o;
   endproperty
   a_far_near: assert property (p_far_near) else $error("switch stayed far");
   property p_band;
      meas_valid_i && eff >= crit_ff && {1'b0, eff} <= far_ff |=> $stable(switch_o);
   endproperty
   a_band: assert property (p_band) else $error("switch moved inside band");
   property p_idle_sw;
      !meas_valid_i && !io_wr_i |=> $stable(switch_o);
   endproperty
   a_idle_sw: assert property (p_idle_sw) else $error("switch moved without data");
   property p_no_stream;
      mode_ff && meas_valid_i && !busy_o |=> !busy_o;
   endproperty
   a_no_stream: assert property (p_no_stream) else $error("stream in switch mode");
   property p_rst;
      $fell(reset_i) |-> !tx_valid_o && !busy_o && switch_o && !sda_oe_o && !cmd_valid_o;
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not idle after reset");
   property p_sda;
      sda_oe_o |-> sda_o == 1'b0;
   endproperty
   a_sda: assert property (p_sda) else $error("data pin driven high");
   property p_cmd;
      cmd_valid_o |=> !cmd_valid_o;
   endproperty
   a_cmd: assert property (p_cmd) else $error("command strobe too long");
endmodule

// ===== bench/host_byte_sink.sv
// Byte sink standing for the host at the far end of the result stream.
// Shares the framer's clock; ready is the inverse of the stall input from the bench.
`timescale 1ns/1ps
module host_byte_sink (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       stall_i,
   input  wire logic       tx_valid_i,
   input  wire logic [7:0] tx_data_i,
   output logic            tx_ready_o
);
   logic [7:0] got[$];
   // The host only listens on this path and never sends back.
   assign tx_ready_o = !stall_i;
   always @(posedge clk_i) begin
      if (!reset_i && tx_valid_i && tx_ready_o) begin
         got.push_back(tx_data_i);
      end
   end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench: framer, byte sink and I2C master.
// Drives inputs on the falling edge of a 200 MHz clock.
`timescale 1ns/1ps
module tb_top;
   import framer_pkg::*;
   logic        clk_i, reset_i, meas_valid_i, fmt_wr_i, fmt_text_i, io_wr_i, io_mode_i;
   logic        addr_wr_i, tx_ready_i, tx_valid_o, busy_o, switch_o, sda_o, sda_oe_o;
   logic        cmd_valid_o, scl_m, sda_m, sda_line, stall, txt, swm, an;
   logic [15:0] meas_dist_i, meas_strength_i, meas_temp_i, crit_dist_i, hyst_i, ld, ls;
   logic [6:0]  i2c_addr_i;
   logic [7:0]  tx_data_o, cmd_data_o, last_cmd, r;
   logic [31:0] seed, sseed;
   logic [7:0]  exp_q[$];
   logic [15:0] sd[8] = '{16'h0078, 16'h0063, 16'h0096, 16'h0097, 16'h0064, 16'h0032,
                          16'h0063, 16'h1388};
   logic [7:0]  sw_exp = 8'h9d;
   int          fail_count, compares, smode;
   // Open-drain data line with a pull-up.
   assign sda_line = sda_m & !(sda_oe_o & !sda_o);
   range_result_output_framer u_dut (.clk_i(clk_i), .reset_i(reset_i),
      .meas_valid_i(meas_valid_i), .meas_dist_i(meas_dist_i),
      .meas_strength_i(meas_strength_i), .meas_temp_i(meas_temp_i), .fmt_wr_i(fmt_wr_i),
      .fmt_text_i(fmt_text_i), .io_wr_i(io_wr_i), .io_mode_i(io_mode_i),
      .crit_dist_i(crit_dist_i), .hyst_i(hyst_i), .addr_wr_i(addr_wr_i),
      .i2c_addr_i(i2c_addr_i), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o), .busy_o(busy_o), .switch_o(switch_o), .scl_i(scl_m),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .cmd_valid_o(cmd_valid_o),
      .cmd_data_o(cmd_data_o));
   host_byte_sink u_sink (.clk_i(clk_i), .reset_i(reset_i), .stall_i(stall),
      .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(negedge clk_i) begin
      sseed = xs(sseed);
      stall = (smode == 2) || (smode == 1 && sseed[1:0] == 2'h0);
   end
   always @(posedge clk_i) begin
      if (cmd_valid_o === 1'b1) last_cmd <= cmd_data_o;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic results();
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask
   task automatic timeout(input string w);
      $display("MISMATCH %s expected done seen timeout", w);
      fail_count++;
      results();
   endtask
   task automatic push_exp(input logic [15:0] d, s, t);
      logic [15:0] e;
      logic [7:0]  f[8];
      logic [7:0]  sum;
      e = (s < STR_MIN || d > DIST_MAX) ? DIST_MAX : d;
      if (txt) begin
         if (e >= 16'h03e8) exp_q.push_back(CHR_ZERO + 8'(e / 16'h03e8));
         exp_q.push_back(CHR_ZERO + 8'((e / 16'h0064) % 16'h000a));
         exp_q.push_back(CHR_DOT);
         exp_q.push_back(CHR_ZERO + 8'((e / 16'h000a) % 16'h000a));
         exp_q.push_back(CHR_ZERO + 8'(e % 16'h000a));
         exp_q.push_back(CHR_CR);
         exp_q.push_back(CHR_LF);
      end else begin
         f = '{HDR_BYTE, HDR_BYTE, e[7:0], e[15:8], s[7:0], s[15:8], t[7:0], t[15:8]};
         sum = 8'h00;
         foreach (f[i]) begin
            exp_q.push_back(f[i]);
            sum = sum + f[i];
         end
         exp_q.push_back(sum);
      end
   endtask
   task automatic pulse(input logic [15:0] d, s, t);
      @(negedge clk_i);
      meas_valid_i = 1'b1;
      meas_dist_i = d;
      meas_strength_i = s;
      meas_temp_i = t;
      @(negedge clk_i);
      meas_valid_i = 1'b0;
      ld = d;
      ls = s;
   endtask
   task automatic send(input logic [15:0] d, s, t);
      int n;
      for (n = 0; n < 4000 && busy_o !== 1'b0; n++) @(negedge clk_i);
      if (n == 4000) timeout("busy_o");
      pulse(d, s, t);
      if (!swm) push_exp(d, s, t);
      repeat (2) @(negedge clk_i);
   endtask
   task automatic rnd_send(input logic [15:0] lim);
      logic [15:0] d;
      logic [15:0] s;
      seed = xs(seed);
      d = seed[15:0] % lim;
      s = seed[16] ? seed[31:16] : {10'h000, seed[22:17]};
      seed = xs(seed);
      send(d, s, seed[15:0]);
   endtask
   task automatic drain();
      int n;
      for (n = 0; n < 4000 && u_sink.got.size() < exp_q.size(); n++) @(negedge clk_i);
      if (n == 4000) timeout("stream");
      repeat (30) @(negedge clk_i);
      chk("frame_len", 16'(exp_q.size()), 16'(u_sink.got.size()));
      foreach (exp_q[i]) chk("tx_byte", 16'(exp_q[i]), 16'(u_sink.got[i]));
      exp_q.delete();
      u_sink.got.delete();
   endtask
   task automatic cfg(input logic f, m, input logic [15:0] c, h, input logic [6:0] a);
      @(negedge clk_i);
      {fmt_wr_i, fmt_text_i, io_wr_i, io_mode_i, crit_dist_i, hyst_i} = {1'b1, f, 1'b1, m, c, h};
      addr_wr_i = 1'b1;
      i2c_addr_i = a;
      @(negedge clk_i);
      {fmt_wr_i, io_wr_i, addr_wr_i} = 3'b000;
      txt = f;
      swm = m;
   endtask
   task automatic half();
      repeat (16) @(negedge clk_i);
   endtask
   task automatic i2c_edge(input logic s0, input logic s1);
      sda_m = s0;
      half();
      scl_m = 1'b1;
      half();
      sda_m = s1;
      half();
   endtask
   task automatic i2c_byte(input logic [7:0] b, input logic mack);
      for (int i = 8; i >= 0; i--) begin
         sda_m = (i == 0) ? mack : b[i-1];
         half();
         scl_m = 1'b1;
         half();
         if (i > 0) r[i-1] = sda_line;
         else an = sda_line;
         scl_m = 1'b0;
         half();
      end
   endtask
   task automatic i2c_wr(input logic [6:0] a, input logic [7:0] d, input logic ack);
      i2c_edge(1'b1, 1'b0);
      scl_m = 1'b0;
      i2c_byte({a, 1'b0}, 1'b1);
      chk("i2c_ack", 16'(!ack), 16'(an));
      if (ack) begin
         i2c_byte(d, 1'b1);
         chk("cmd_data", 16'(d), 16'(last_cmd));
      end
      i2c_edge(1'b0, 1'b1);
   endtask
   initial begin
      seed = 32'h9578933c;
      sseed = xs(32'h9578933c);
      {smode, stall, txt, swm, scl_m, sda_m, last_cmd} = {32'h0, 5'b00011, 8'h00};
      {meas_valid_i, fmt_wr_i, fmt_text_i, io_wr_i, io_mode_i, addr_wr_i} = 6'h00;
      {meas_dist_i, meas_strength_i, meas_temp_i, crit_dist_i, hyst_i} = '0;
      i2c_addr_i = 7'h00;
      reset_i = 1'b1;
      repeat (8) @(negedge clk_i);
      reset_i = 1'b0;
      chk("switch_rst", 16'(SW_FAR), 16'(switch_o));
      send(16'h0000, 16'h003c, 16'h0000);
      send(16'h0100, 16'h003b, 16'hffff);
      send(16'h1195, 16'hffff, 16'h0800);
      smode = 1;
      for (int i = 0; i < 20; i++) rnd_send(16'h1400);
      drain();
      smode = 2;
      send(16'h0203, 16'h0405, 16'h0607);
      for (int n = 0; n < 50 && busy_o !== 1'b1; n++) @(negedge clk_i);
      pulse(16'h0111, 16'h0222, 16'h0333);
      smode = 1;
      drain();
      cfg(1'b1, 1'b0, 16'h0000, 16'h0000, 7'h10);
      foreach (sd[i]) send(16'h0079 + sd[i] % 16'h03f0, 16'h0100, 16'h0000);
      send(16'h0005, 16'h0100, 16'h0000);
      for (int i = 0; i < 8; i++) rnd_send(16'h1200);
      drain();
      cfg(1'b0, 1'b0, 16'h0000, 16'h0000, 7'h10);
      send(16'h03e8, 16'h1234, 16'h0abc);
      drain();
      cfg(1'b0, 1'b1, 16'h0064, 16'h0032, 7'h10);
      foreach (sd[i]) begin
         send(sd[i], (i == 5) ? 16'h000a : 16'h0100, 16'h0000);
         chk("switch", 16'(sw_exp[7-i]), 16'(switch_o));
         chk("busy_sw", 16'h0000, 16'(busy_o));
      end
      drain();
      // Write, short pause, then read of the snapshot.
      i2c_wr(7'h10, 8'ha5, 1'b1);
      repeat (200) @(negedge clk_i);
      i2c_edge(1'b1, 1'b0);
      scl_m = 1'b0;
      i2c_byte({I2C_ADDR_RST, 1'b1}, 1'b1);
      chk("i2c_ack", 16'h0000, 16'(an));
      for (int i = 0; i < 3; i++) begin
         i2c_byte(8'hff, i == 2);
         chk("i2c_rd", (i == 2) ? 16'h0094 : 16'(HDR_BYTE), 16'(r));
      end
      i2c_edge(1'b0, 1'b1);
      i2c_wr(7'h11, 8'h00, 1'b0);
      cfg(1'b0, 1'b0, 16'h0000, 16'h0000, 7'h22);
      cfg(1'b0, 1'b0, 16'h0000, 16'h0000, 7'h00);
      i2c_wr(7'h10, 8'h00, 1'b0);
      i2c_wr(7'h22, 8'h3c, 1'b1);
      results();
   end
endmodule
bind range_result_output_framer framer_sva u_sva (.clk_i(clk_i), .reset_i(reset_i),
   .meas_valid_i(meas_valid_i), .meas_dist_i(meas_dist_i),
   .meas_strength_i(meas_strength_i), .fmt_wr_i(fmt_wr_i), .fmt_text_i(fmt_text_i),
   .io_wr_i(io_wr_i), .io_mode_i(io_mode_i), .crit_dist_i(crit_dist_i), .hyst_i(hyst_i),
   .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
   .busy_o(busy_o), .switch_o(switch_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .cmd_valid_o(cmd_valid_o));
